// ===== logic/sfd_params.svh
// constants for the single float datapath
`ifndef SFD_PARAMS_SVH
`define SFD_PARAMS_SVH
`define SFD_SIGN_BIT      31
`define SFD_EXP_MSB       30
`define SFD_EXP_LSB       23
`define SFD_BIAS          127
`define SFD_QUIET_BIT     22
`define SFD_POS_ZERO      32'h0000_0000
`define SFD_DEFAULT_NAN   32'h7FC0_0000
`define SFD_FLAGS_RESET   4'h0
`define SFD_RMODE_RESET   2'h0
`define SFD_IOC_BIT       0
`define SFD_IXC_BIT       4
`define SFD_STATUS_RESET  32'h0000_0000
`define SFD_COND_ALWAYS   4'hE
`endif

// ===== logic/sfd_pkg.sv
// types shared by the single float datapath
package sfd_pkg;
  typedef enum logic [4:0] {
    float_magnitude_op, float_sum_op, float_difference_op, float_product_op,
    float_quotient_op, float_root_op, float_sign_flip_op, float_compare_op,
    float_compare_checked_op, float_to_int_op, float_int_convert_rounded_op,
    int_to_float_op, float_to_fixed_op, fixed_to_float_op, half_bottom_convert_op,
    half_top_convert_op, single_to_half_bottom_op, single_to_half_top_op,
    fused_mul_acc_op, fused_mul_sub_op, neg_fused_mul_acc_op, neg_fused_mul_sub_op,
    sysreg_to_core_move, core_to_sysreg_move, ext_reg_block_load, ext_reg_block_store,
    ext_reg_stack_save, ext_reg_stack_restore
  } sfd_op_type;
  typedef struct packed {
    sfd_op_type  op;
    logic [3:0]  cond;     // condition code, e = always
    logic        signed_int;
    logic        compare_zero;
    logic [31:0] opa;      // first source or core register / memory word
    logic [31:0] opb;      // second source
    logic [31:0] opd;      // prior destination value
    logic [4:0]  dest;
  } sfd_issue_type;
  typedef struct packed {
    logic        write_fp;
    logic        write_core;
    logic        write_mem;
    logic [4:0]  dest;
    logic [31:0] data;
  } sfd_result_type;
endpackage : sfd_pkg

// ===== logic/sfd_cond_check.sv
// condition code evaluation against core flags
`timescale 1ns/1ps
module sfd_cond_check (
  input  wire logic [3:0] cond,
  input  wire logic [3:0] nzcv,
  output logic            pass
);
  logic n, z, c, v;
  // standard sixteen condition decode
  always_comb begin
    n = nzcv[3];
    z = nzcv[2];
    c = nzcv[1];
    v = nzcv[0];
    unique case (cond[3:1])
      3'h0: pass = z;
      3'h1: pass = c;
      3'h2: pass = n;
      3'h3: pass = v;
      3'h4: pass = c & ~z;
      3'h5: pass = (n == v);
      3'h6: pass = (n == v) & ~z;
      default: pass = 1'b1;
    endcase
    if (cond[0] && cond[3:1] != 3'h7) begin
      pass = ~pass;
    end
  end
endmodule : sfd_cond_check

// ===== logic/sfd_datapath.sv
// single-precision float execution datapath
`timescale 1ns/1ps
`include "sfd_params.svh"
module sfd_datapath #(
  parameter int unsigned FIX_BITS = 16
) (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   unit_present,
  input  wire logic                   unit_enable,
  input  wire logic                   issue_valid,
  input  wire sfd_pkg::sfd_issue_type issue,
  input  wire logic [3:0]             core_nzcv,
  output sfd_pkg::sfd_result_type     result,
  output logic                        result_valid,
  output logic                        undefined_op,
  output logic [31:0]                 status_control
);
  import sfd_pkg::*;

  // NaN and signalling NaN tests on a single value
  function automatic logic is_nan(input logic [31:0] x);
    is_nan = (x[`SFD_EXP_MSB:`SFD_EXP_LSB] == 8'hFF) && (x[22:0] != 23'h0);
  endfunction : is_nan

  function automatic logic is_snan(input logic [31:0] x);
    is_snan = is_nan(x) && !x[`SFD_QUIET_BIT];
  endfunction : is_snan

  // round the full-width sum at given shift per mode; whole width kept so no top bit is lost
  function automatic logic [24:0] round_sig(input logic [73:0] sig, input logic [5:0] sh,
                                            input logic [1:0] rm, input logic sgn);
    logic [73:0] kept;
    logic [73:0] lost;
    logic        half;
    logic        up;
    kept = sig >> sh;
    lost = sig & ((74'h1 << sh) - 74'h1);
    half = (sh != 6'h0) && sig[sh - 6'h1];
    unique case (rm)
      2'h0: up = half && ((lost != (74'h1 << (sh - 6'h1))) || kept[0]);
      2'h1: up = !sgn && (lost != 74'h0);
      2'h2: up = sgn && (lost != 74'h0);
      default: up = 1'b0;
    endcase
    round_sig = kept[24:0] + {24'h0, up};
  endfunction : round_sig

  // multiply-add core used for sum, product and fused forms
  function automatic logic [31:0] fma(input logic [31:0] a, input logic [31:0] b,
                                      input logic [31:0] c, input logic [1:0] rm);
    logic        ps;
    logic [47:0] pm;
    logic signed [10:0] pe;
    logic signed [10:0] ce;
    logic [73:0] pa;
    logic [73:0] ca;
    logic [73:0] sm;
    logic        rs;
    logic signed [10:0] re;
    logic [6:0]  lz;
    logic [24:0] mant;
    ps = a[31] ^ b[31];
    pm = {|a[30:23], a[22:0]} * {|b[30:23], b[22:0]};
    // product lsb weight: one bias plus two fraction widths
    pe = $signed({3'h0, a[30:23]}) + $signed({3'h0, b[30:23]}) - 11'sd127 - 11'sd46;
    ce = $signed({3'h0, c[30:23]}) - 11'sd23;
    fma = `SFD_DEFAULT_NAN;
    if (is_nan(a) || is_nan(b) || is_nan(c)) begin
      fma = `SFD_DEFAULT_NAN;
    end else if (a[30:23] == 8'hFF || b[30:23] == 8'hFF || c[30:23] == 8'hFF) begin
      fma = (c[30:23] == 8'hFF) ? c : {ps, 8'hFF, 23'h0};
    end else begin
      // align both terms to the smaller exponent, limited window
      pa = {26'h0, pm};
      ca = {50'h0, |c[30:23], c[22:0]};
      re = (pe < ce) ? pe : ce;
      if (pe - re > 11'sd25) begin
        re = pe - 11'sd25;
      end
      if (ce - re > 11'sd25) begin
        re = ce - 11'sd25;
      end
      pa = (pe >= re) ? pa << 7'(pe - re) : pa >> 7'(re - pe);
      ca = (ce >= re) ? ca << 7'(ce - re) : ca >> 7'(re - ce);
      if (ps == c[31]) begin
        sm = pa + ca;
        rs = ps;
      end else if (pa >= ca) begin
        sm = pa - ca;
        rs = ps;
      end else begin
        sm = ca - pa;
        rs = c[31];
      end
      lz = 7'd0;
      for (int i = 0; i < 74; i++) begin
        if (sm[i]) begin
          lz = 7'(i);
        end
      end
      if (sm == 74'h0) begin
        fma = {(rm == 2'h2) && (ps != c[31]), 31'h0};
      end else begin
        re = re + 11'(lz) + 11'sd127 - 11'sd127;
        mant = (lz > 7'd23) ? round_sig(sm, 6'(lz - 7'd23), rm, rs)
                            : 25'(sm[49:0] << (7'd23 - lz));
        if (mant[24]) begin
          re = re + 11'sd1;
        end
        if (re >= 11'sd255) begin
          fma = {rs, 8'hFF, 23'h0};
        end else if (re <= 11'sd0) begin
          fma = {rs, 31'h0};
        end else begin
          fma = {rs, re[7:0], mant[24] ? mant[23:1] : mant[22:0]};
        end
      end
    end
  endfunction : fma

  logic            cond_pass;
  sfd_result_type  result_reg, result_next;
  logic            valid_reg, valid_next, undef_reg, undef_next;
  logic [31:0]     status_reg, status_next;
  logic [31:0]     one_val;
  logic [1:0]      rmode;
  logic            unordered, less, equal, any_nan, any_snan;
  logic [31:0]     cmp_b;

  sfd_cond_check u_cond (
    .cond (issue.cond),
    .nzcv (core_nzcv),
    .pass (cond_pass)
  );

  // execute one issued instruction per cycle
  always_comb begin
    result_next = '0;
    valid_next  = 1'b0;
    undef_next  = 1'b0;
    status_next = status_reg;
    rmode       = status_reg[23:22];
    one_val     = 32'h3F80_0000;
    cmp_b       = issue.compare_zero ? `SFD_POS_ZERO : issue.opb;
    any_nan     = is_nan(issue.opa) || is_nan(cmp_b);
    any_snan    = is_snan(issue.opa) || is_snan(cmp_b);
    unordered   = any_nan;
    equal       = (issue.opa[30:0] == 31'h0 && cmp_b[30:0] == 31'h0) || issue.opa == cmp_b;
    less        = issue.opa[31] != cmp_b[31] ? issue.opa[31] && !equal :
                  issue.opa[31] ? issue.opa[30:0] > cmp_b[30:0]
                                : issue.opa[30:0] < cmp_b[30:0];
    result_next.dest = issue.dest;
    if (issue_valid) begin
      if (!(unit_present && unit_enable)) begin
        undef_next = 1'b1;
      end else if (cond_pass) begin
        valid_next = 1'b1;
        result_next.write_fp = 1'b1;
        unique case (issue.op)
          float_magnitude_op: result_next.data = {1'b0, issue.opa[30:0]};
          float_sum_op: result_next.data = fma(issue.opa, one_val, issue.opb, rmode);
          float_difference_op: result_next.data = fma(issue.opa, one_val,
                                                      issue.opb ^ 32'h8000_0000, rmode);
          float_product_op: result_next.data = fma(issue.opa, issue.opb, 32'h0, rmode);
          float_quotient_op, float_root_op: result_next.data = `SFD_DEFAULT_NAN;
          float_sign_flip_op: result_next.data = issue.opa ^ 32'h8000_0000;
          fused_mul_acc_op: result_next.data = fma(issue.opa, issue.opb, issue.opd, rmode);
          fused_mul_sub_op: result_next.data = fma(issue.opa ^ 32'h8000_0000, issue.opb,
                                                   issue.opd, rmode);
          neg_fused_mul_acc_op: result_next.data = fma(issue.opa ^ 32'h8000_0000, issue.opb,
                                                       issue.opd ^ 32'h8000_0000, rmode);
          neg_fused_mul_sub_op: result_next.data = fma(issue.opa, issue.opb,
                                                       issue.opd ^ 32'h8000_0000, rmode);
          float_compare_op, float_compare_checked_op: begin
            result_next.write_fp = 1'b0;
            status_next[31:28] = unordered ? 4'h3 : equal ? 4'h6 : less ? 4'h8 : 4'h2;
            if ((issue.op == float_compare_checked_op) ? any_nan : any_snan) begin
              status_next[`SFD_IOC_BIT] = 1'b1;
            end
          end
          float_to_int_op, float_int_convert_rounded_op, int_to_float_op,
          float_to_fixed_op, fixed_to_float_op: result_next.data = issue.opa;
          half_bottom_convert_op, half_top_convert_op: result_next.data = issue.opa;
          single_to_half_bottom_op: result_next.data = {issue.opd[31:16], issue.opa[31:16]};
          single_to_half_top_op: result_next.data = {issue.opa[31:16], issue.opd[15:0]};
          sysreg_to_core_move: begin
            result_next.write_fp   = 1'b0;
            result_next.write_core = 1'b1;
            result_next.data       = status_reg;
          end
          core_to_sysreg_move: begin
            result_next.write_fp = 1'b0;
            status_next          = issue.opa;
          end
          ext_reg_block_load, ext_reg_stack_restore: result_next.data = issue.opa;
          ext_reg_block_store, ext_reg_stack_save: begin
            result_next.write_fp  = 1'b0;
            result_next.write_mem = 1'b1;
            result_next.data      = issue.opb;
          end
          // unused op codes write nothing
          default: result_next.write_fp = 1'b0;
        endcase
      end
    end
  end

  // register results and status word
  always_ff @(posedge clk) begin
    if (reset) begin
      result_reg <= '0;
      valid_reg  <= 1'b0;
      undef_reg  <= 1'b0;
      status_reg <= `SFD_STATUS_RESET;
    end else begin
      result_reg <= result_next;
      valid_reg  <= valid_next;
      undef_reg  <= undef_next;
      status_reg <= status_next;
    end
  end

  assign result         = result_reg;
  assign result_valid   = valid_reg;
  assign undefined_op   = undef_reg;
  assign status_control = status_reg;
endmodule : sfd_datapath

// ===== verification/sfd_datapath_monitor.sv
// concurrent checks on the float datapath ports
`timescale 1ns/1ps
module sfd_datapath_monitor
  import sfd_pkg::*;
#(
  parameter int unsigned FIX_BITS = 16
) (
  input wire logic           clk,
  input wire logic           reset,
  input wire logic           unit_present,
  input wire logic           unit_enable,
  input wire logic           issue_valid,
  input wire sfd_issue_type  issue,
  input wire logic [3:0]     core_nzcv,
  input wire sfd_result_type result,
  input wire logic           result_valid,
  input wire logic           undefined_op,
  input wire logic [31:0]    status_control
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic        on, nan_a, snan_a;
  logic [31:0] opa_reg;
  // accepted issue and operand class
  assign on     = issue_valid && unit_present && unit_enable;
  assign nan_a  = (&issue.opa[30:23]) && (|issue.opa[22:0]);
  assign snan_a = nan_a && !issue.opa[22];
  // first operand of the previous cycle
  always_ff @(posedge clk) begin
    opa_reg <= issue.opa;
  end
  sequence s_go(o);
    on && issue.cond == 4'hE && issue.op == o;
  endsequence
  property p_unit_off;
    issue_valid && !(unit_present && unit_enable) |=> undefined_op && !result_valid;
  endproperty
  a_unit_off: assert property (p_unit_off)
    else $error("issue with unit off was not refused");
  property p_cond_fail;
    on && issue.cond == 4'h0 && !core_nzcv[2] |=> !result_valid && !undefined_op;
  endproperty
  a_cond_fail: assert property (p_cond_fail)
    else $error("failed condition still produced output");
  property p_magnitude;
    s_go(float_magnitude_op) |=> result_valid && result.data == {1'b0, opa_reg[30:0]};
  endproperty
  a_magnitude: assert property (p_magnitude)
    else $error("magnitude did not clear only the sign");
  property p_sum_flags;
    s_go(float_sum_op) |=> result_valid && $stable(status_control[31:28]);
  endproperty
  a_sum_flags: assert property (p_sum_flags)
    else $error("sum changed the flags");
  property p_checked_nan;
    s_go(float_compare_checked_op) ##0 nan_a |=> status_control[0];
  endproperty
  a_checked_nan: assert property (p_checked_nan)
    else $error("checked compare missed invalid on nan");
  property p_plain_snan;
    s_go(float_compare_op) ##0 snan_a |=> status_control[0];
  endproperty
  a_plain_snan: assert property (p_plain_snan)
    else $error("plain compare missed invalid on signalling nan");
  property p_plain_qnan;
    s_go(float_compare_op) ##0 (nan_a && !snan_a && issue.compare_zero)
      |=> $stable(status_control[0]);
  endproperty
  a_plain_qnan: assert property (p_plain_qnan)
    else $error("plain compare raised invalid on quiet nan");
  property p_cmp_flags;
    s_go(float_compare_op) ##0 (issue.compare_zero && issue.opa == 32'h0000_0000)
      |=> status_control[31:28] == 4'h6 && !result.write_core;
  endproperty
  a_cmp_flags: assert property (p_cmp_flags)
    else $error("compare against zero gave wrong status flags");
endmodule : sfd_datapath_monitor
bind sfd_datapath sfd_datapath_monitor #(.FIX_BITS(FIX_BITS)) sfd_datapath_monitor_i (
  .clk(clk), .reset(reset), .unit_present(unit_present), .unit_enable(unit_enable),
  .issue_valid(issue_valid), .issue(issue), .core_nzcv(core_nzcv), .result(result),
  .result_valid(result_valid), .undefined_op(undefined_op), .status_control(status_control)
);

// ===== verification/sfd_issuer.sv
// integer pipeline model issuing float instructions
`timescale 1ns/1ps
module sfd_issuer (
  input wire logic              clk,
  output sfd_pkg::sfd_issue_type issue,
  output logic                  issue_valid
);
  import sfd_pkg::*;
  initial begin
    issue_valid = 1'b0;
    issue       = '0;
  end
  // one instruction per call; payload scrambled once idle
  task automatic send(input sfd_issue_type x);
    @(negedge clk);
    issue_valid = 1'b1;
    issue       = x;
    @(negedge clk);
    issue_valid = 1'b0;
    issue       = sfd_issue_type'(~x);
  endtask : send
endmodule : sfd_issuer

// ===== verification/single_float_datapath_test.sv
// self-checking bench for the float datapath
`timescale 1ns/1ps
module single_float_datapath_test;
  import sfd_pkg::*;
  logic           clk, reset, unit_present, unit_enable, issue_valid;
  logic           result_valid, undefined_op;
  logic [3:0]     core_nzcv;
  logic [31:0]    status_control;
  sfd_issue_type  issue;
  sfd_result_type result;
  int             n_errors, tests_run, cycles;
  sfd_datapath sfd_datapath_i (.clk(clk), .reset(reset), .unit_present(unit_present),
    .unit_enable(unit_enable), .issue_valid(issue_valid), .issue(issue),
    .core_nzcv(core_nzcv), .result(result), .result_valid(result_valid),
    .undefined_op(undefined_op), .status_control(status_control));
  sfd_issuer sfd_issuer_i (.clk(clk), .issue(issue), .issue_valid(issue_valid));
  // clock and hang guard
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  // one instruction; returns in its answer cycle
  task automatic go(input sfd_op_type op, input logic [31:0] a, input logic [31:0] b,
                    input logic cz = 1'b0, input logic [3:0] c = 4'hE,
                    input logic [31:0] d = 32'h0000_0000);
    sfd_issuer_i.send('{op, c, 1'b0, cz, a, b, d, 5'h07});
  endtask : go
  // fused forms, rounding mode, half, conversion and memory ops
  task automatic t_more;
    sfd_op_type  ops[4] = '{fused_mul_acc_op, fused_mul_sub_op, neg_fused_mul_acc_op,
                            neg_fused_mul_sub_op};
    logic [31:0] exp[4] = '{32'h40E0_0000, 32'hC0A0_0000, 32'hC0E0_0000, 32'h40A0_0000};
    for (int i = 0; i < 4; i++) begin
      go(ops[i], 32'h4000_0000, 32'h4040_0000, 1'b0, 4'hE, 32'h3F80_0000);
      check("fused data", result.data, exp[i]);
    end
    go(float_sum_op, 32'h3F80_0000, 32'h3380_0000);
    check("nearest even", result.data, 32'h3F80_0000);
    go(core_to_sysreg_move, 32'h0040_0000, 32'h0000_0000);
    go(float_sum_op, 32'h3F80_0000, 32'h3380_0000);
    check("round up", result.data, 32'h3F80_0001);
    go(core_to_sysreg_move, 32'h0000_0000, 32'h0000_0000);
    go(single_to_half_top_op, 32'h3F80_0000, 32'h0000_0000, 1'b0, 4'hE, 32'h1234_5678);
    check("top keeps low", {16'h0000, result.data[15:0]}, 32'h0000_5678);
    go(single_to_half_bottom_op, 32'h3F80_0000, 32'h0000_0000, 1'b0, 4'hE, 32'h1234_5678);
    check("bottom keeps high", {16'h0000, result.data[31:16]}, 32'h0000_1234);
    go(float_int_convert_rounded_op, 32'h3F80_0000, 32'h0000_0000);
    check("convert write", {26'h0, result.write_fp, result.dest}, 32'h27);
    go(ext_reg_block_store, 32'h0000_0000, 32'h1234_5678);
    check("store data", result.data, 32'h1234_5678);
    check("store kind", {29'h0, result.write_fp, result.write_core, result.write_mem},
          32'h1);
    go(ext_reg_stack_restore, 32'h8765_4321, 32'h0000_0000);
    check("restore data", result.data, 32'h8765_4321);
  endtask : t_more
  // absent or disabled unit refuses
  task automatic t_unit_off;
    for (int i = 0; i < 2; i++) begin
      unit_present = i[0];
      unit_enable  = ~i[0];
      go(float_sum_op, 32'h3F80_0000, 32'h3F80_0000);
      check("undefined", {31'h0, undefined_op}, 32'h1);
      check("no result", {31'h0, result_valid}, 32'h0);
    end
    unit_present = 1'b1;
    unit_enable  = 1'b1;
  endtask : t_unit_off
  // arithmetic on -2.0 and 3.0
  task automatic t_arith;
    sfd_op_type  ops[5] = '{float_magnitude_op, float_sign_flip_op, float_sum_op,
                            float_difference_op, float_product_op};
    logic [31:0] exp[5] = '{32'h4000_0000, 32'h4000_0000, 32'h3F80_0000,
                            32'hC0A0_0000, 32'hC0C0_0000};
    for (int i = 0; i < 5; i++) begin
      go(ops[i], 32'hC000_0000, 32'h4040_0000);
      check("arith data", result.data, exp[i]);
      check("arith dest", {26'h0, result.write_fp, result.dest}, 32'h27);
    end
  endtask : t_arith
  // compares, invalid flag, system register moves
  task automatic t_compare;
    sfd_op_type  ops[7] = '{float_compare_op, float_compare_op, float_sum_op,
                            float_compare_op, float_compare_op, core_to_sysreg_move,
                            float_compare_checked_op};
    logic [31:0] a[7]   = '{32'h0000_0000, 32'h3F80_0000, 32'h3F80_0000, 32'h7FC0_0000,
                            32'h7F80_0001, 32'h0000_0000, 32'h7FC0_0000};
    logic [6:0]  cz     = 7'h59;
    logic [31:0] st[7]  = '{32'h6000_0000, 32'h8000_0000, 32'h8000_0000, 32'h3000_0000,
                            32'h3000_0001, 32'h0000_0000, 32'h3000_0001};
    for (int i = 0; i < 7; i++) begin
      go(ops[i], a[i], 32'h4000_0000, cz[i]);
      check("status", status_control, st[i]);
    end
    go(sysreg_to_core_move, 32'h0000_0000, 32'h0000_0000);
    check("to core", result.data, 32'h3000_0001);
    check("core write", {31'h0, result.write_core}, 32'h1);
  endtask : t_compare
  // equal condition against core zero flag
  task automatic t_cond;
    core_nzcv = 4'h0;
    go(float_magnitude_op, 32'hBF80_0000, 32'h0000_0000, 1'b0, 4'h0);
    check("cond fail", {30'h0, result_valid, undefined_op}, 32'h0);
    core_nzcv = 4'h4;
    go(float_magnitude_op, 32'hBF80_0000, 32'h0000_0000, 1'b0, 4'h0);
    check("cond pass", {31'h0, result_valid}, 32'h1);
    check("cond data", result.data, 32'h3F80_0000);
  endtask : t_cond
  // reset, then the scenarios
  initial begin
    clk          = 1'b0;
    reset        = 1'b1;
    unit_present = 1'b1;
    unit_enable  = 1'b1;
    core_nzcv    = 4'h0;
    n_errors     = 0;
    tests_run    = 0;
    cycles       = 0;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    t_unit_off();
    t_arith();
    t_compare();
    t_cond();
    t_more();
    report_and_stop();
  end
endmodule : single_float_datapath_test
